// ### hw/adc_seq_pkg.sv
// Package with register map, field layout and timing constants of the converter control
package adc_seq_pkg;

	// ****************************************
	// Register indices and byte addresses
	// ****************************************
	localparam logic [31:0] reg_index_control = 32'h0000_7f20;
	localparam logic [31:0] reg_index_mode = 32'h0000_7f21;
	localparam logic [31:0] reg_index_result_low = 32'h0000_7f22;
	localparam logic [31:0] reg_index_result_high = 32'h0000_7f23;
	localparam logic [31:0] addr_control = {reg_index_control[29:0], 2'b00};
	localparam logic [31:0] addr_mode = {reg_index_mode[29:0], 2'b00};
	localparam logic [31:0] addr_result_low = {reg_index_result_low[29:0], 2'b00};
	localparam logic [31:0] addr_result_high = {reg_index_result_high[29:0], 2'b00};

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ctrl_channel_msb = 7;
	localparam int ctrl_channel_lsb = 4;
	localparam int ctrl_compare_bit = 3;
	localparam int ctrl_start_bit = 2;
	localparam int ctrl_done_bit = 1;
	localparam int ctrl_irq_enable_bit = 0;
	localparam int mode_resolution_bit = 6;
	localparam int mode_offset_bit = 2;
	localparam int mode_md_msb = 1;
	localparam int mode_md_lsb = 0;
	localparam int low_data_msb = 7;
	localparam int low_data_lsb = 4;
	localparam int low_compare_result_bit = 7;
	localparam int low_divide_high_bit = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [7:0] mode_reset = 8'h00;
	localparam logic [7:0] result_low_reset = 8'h00;
	localparam logic [7:0] result_high_reset = 8'h00;

	// ****************************************
	// Timing, in units of 2^code pclk each; overhead in pclk cycles
	// ****************************************
	localparam logic [7:0] conv12_units = 8'h34;
	localparam logic [7:0] conv8_units = 8'h20;
	localparam logic [7:0] compare_units = 8'h1c;
	localparam logic [15:0] conv_overhead = 16'h0002;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {st_idle, st_run} op_state_t;

endpackage

// ### hw/adc_level_sync.sv
// Two-flop synchroniser for the digitised analog input level
`timescale 1ns/1ps
module adc_level_sync
	import adc_seq_pkg::*;
#(
	parameter int width = 12
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Level in and out
	input wire logic [width-1:0] level_in,
	output logic [width-1:0] level_out
);

	logic [width-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < width; i++)
		begin : g_bit
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					stage1[i] <= 1'b0;
					level_out[i] <= 1'b0;
				end
				else
				begin
					stage1[i] <= level_in[i];
					level_out[i] <= stage1[i];
				end
			end
		end
	endgenerate

endmodule

// ### hw/adc_cycle_timer.sv
// Operation timer loaded from mode and division settings
`timescale 1ns/1ps
module adc_cycle_timer
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic load,
	input wire logic abort,
	input wire logic [2:0] divide_code,
	input wire logic [7:0] units,
	input wire logic double_time,
	// Status
	output logic expired,
	output logic running
);

	logic [15:0] count;
	logic [15:0] base_count;
	logic [15:0] load_count;

	// Units scaled by 2^code, plus fixed overhead
	assign base_count = ({8'h00, units} << divide_code) + conv_overhead;
	assign load_count = double_time ? {base_count[14:0], 1'b0} : base_count;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= 16'h0000;
			running <= 1'b0;
			expired <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (load)
			begin
				count <= load_count;
				running <= 1'b1;
			end
			else if (abort)
			begin
				running <= 1'b0;
			end
			else if (running)
			begin
				// One cycle early; the done flag register adds the last
				if (count == 16'h0002)
				begin
					running <= 1'b0;
					expired <= 1'b1;
				end
				count <= count - 16'h0001;
			end
		end
	end

endmodule

// ### hw/adc_sequencing_control.sv
// Sequencing control of the successive-approximation converter with APB registers
//
// Notes on behaviour
// - High divide bit 1 with low code 01 gives division by 32.
// - Channel field, control bits 7..4, routes the chosen input; 0001 is input 1.
// - Writing 1 to start, control bit 2, begins an operation with current settings.
// - On finishing, done flag sets and start clears in the same cycle.
// - Done flag at control bit 1 stays set until software writes 0.
// - A comparison lasts 28 times division factor plus 2 cycles.
// - After comparison, low byte bit 7 is 1 when reference is below input.
// - Repeating needs only a new start; mode, division and channel are kept.
// - Writing 0 to start mid-operation aborts it; results are then invalid.
// - Reset clears start and halts the converter at once.
// - With interrupt enable set, completion raises the interrupt request.
// - Three-bit division code 000..111 maps to factors 1 through 128.
// - 12-bit takes 52 units, 8-bit takes 32 units, each plus 2 cycles.
// - 12-bit result: top 8 to high byte, low 4 to low bits 7..4.
// - First 12-bit conversion after reset or after 8-bit mode takes double time.
`timescale 1ns/1ps
module adc_sequencing_control
	import adc_seq_pkg::*;
#(
	parameter logic [7:0] conv12_time_units = conv12_units,
	parameter logic [7:0] conv8_time_units = conv8_units,
	parameter logic [7:0] compare_time_units = compare_units
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog sampling and comparison circuitry
	input wire logic [11:0] analog_input_level,
	output logic [3:0] input_channel_select,
	output logic sample_enable,
	output logic offset_compensation_enable,
	output logic comparator_mode_select,
	output logic resolution_select,
	// Completion interrupt request
	output logic done_irq
);

	// ****************************************
	// Declarations
	// ****************************************
	op_state_t state;
	op_state_t next_state;
	logic conversion_done_flag;
	logic done_interrupt_enable;
	logic [1:0] clock_divide_low;
	logic clock_divide_high;
	logic [3:0] result_low_data;
	logic [7:0] result_high_byte;
	logic need_double;
	logic run_compare;
	logic run_low_res;
	logic [11:0] level_sync;
	logic setup_phase;
	logic write_access;
	logic [2:0] decoded;
	logic wr_control;
	logic wr_mode;
	logic wr_low;
	logic wr_high;
	logic launch;
	logic abort;
	logic expired;
	logic [7:0] op_units;
	logic double_time;
	logic [7:0] read_byte;

	// ****************************************
	// Address decode
	// ****************************************
	// Returns {hit, index}
	function automatic logic [2:0] reg_decode(input logic [31:0] addr);
		logic [2:0] result;
		result = 3'b000;
		case (addr)
			addr_control: result = 3'b100;
			addr_mode: result = 3'b101;
			addr_result_low: result = 3'b110;
			addr_result_high: result = 3'b111;
			default: result = 3'b000;
		endcase
		return result;
	endfunction

	assign decoded = reg_decode(paddr);
	assign setup_phase = psel & ~penable;
	assign write_access = psel & penable & pready & pwrite;
	assign wr_control = write_access & (reg_decode(paddr) == 3'b100);
	assign wr_mode = write_access & (reg_decode(paddr) == 3'b101);
	assign wr_low = write_access & (reg_decode(paddr) == 3'b110);
	assign wr_high = write_access & (reg_decode(paddr) == 3'b111);

	// ****************************************
	// APB answer
	// ****************************************
	always_comb
	begin
		case (decoded)
			3'b100: read_byte = {input_channel_select, comparator_mode_select,
				state == st_run, conversion_done_flag, done_interrupt_enable};
			3'b101: read_byte = {1'b0, resolution_select, 3'b000,
				offset_compensation_enable, clock_divide_low};
			3'b110: read_byte = {result_low_data, 3'b000, clock_divide_high};
			3'b111: read_byte = result_high_byte;
			default: read_byte = 8'h00;
		endcase
	end

	// One wait-free access phase; data ready at the end of setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_phase;
			pslverr <= setup_phase & ~decoded[2];
			if (setup_phase && !pwrite)
			begin
				prdata <= {24'h000000, read_byte};
			end
		end
	end

	// ****************************************
	// Start, abort and state
	// ****************************************
	// New start from idle
	assign launch = wr_control & pwdata[ctrl_start_bit] & (state == st_idle);
	assign abort = wr_control & ~pwdata[ctrl_start_bit] & (state == st_run);

	always_comb
	begin
		next_state = state;
		case (state)
			st_idle:
			begin
				if (launch)
				begin
					next_state = st_run;
				end
			end
			st_run:
			begin
				if (expired || abort)
				begin
					next_state = st_idle;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	// Reset drops start and stops sampling at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= st_idle;
			sample_enable <= 1'b0;
		end
		else
		begin
			state <= next_state;
			sample_enable <= (next_state == st_run);
		end
	end

	// Mode captured at launch for result routing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_compare <= 1'b0;
			run_low_res <= 1'b0;
		end
		else if (launch)
		begin
			run_compare <= comparator_mode_select;
			run_low_res <= resolution_select;
		end
	end

	// ****************************************
	// Control register fields
	// ****************************************
	// Channel, compare select and interrupt enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			input_channel_select <= control_reset[ctrl_channel_msb:ctrl_channel_lsb];
			comparator_mode_select <= control_reset[ctrl_compare_bit];
			done_interrupt_enable <= control_reset[ctrl_irq_enable_bit];
		end
		else if (wr_control)
		begin
			input_channel_select <= pwdata[ctrl_channel_msb:ctrl_channel_lsb];
			comparator_mode_select <= pwdata[ctrl_compare_bit];
			done_interrupt_enable <= pwdata[ctrl_irq_enable_bit];
		end
	end

	// Sticky done flag, set wins over a clearing write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conversion_done_flag <= control_reset[ctrl_done_bit];
		end
		else if (expired)
		begin
			conversion_done_flag <= 1'b1;
		end
		else if (wr_control && !pwdata[ctrl_done_bit])
		begin
			conversion_done_flag <= 1'b0;
		end
	end

	// Interrupt request follows flag and enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_irq <= 1'b0;
		end
		else
		begin
			done_irq <= conversion_done_flag & done_interrupt_enable;
		end
	end

	// ****************************************
	// Mode register fields
	// ****************************************
	// Resolution and division settings kept across operations
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resolution_select <= mode_reset[mode_resolution_bit];
			offset_compensation_enable <= mode_reset[mode_offset_bit];
			clock_divide_low <= mode_reset[mode_md_msb:mode_md_lsb];
		end
		else if (wr_mode)
		begin
			resolution_select <= pwdata[mode_resolution_bit];
			offset_compensation_enable <= pwdata[mode_offset_bit];
			clock_divide_low <= pwdata[mode_md_msb:mode_md_lsb];
		end
	end

	// Double time pending after reset or any time in 8-bit mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			need_double <= 1'b1;
		end
		else if (resolution_select)
		begin
			need_double <= 1'b1;
		end
		else if (expired && !run_compare && !run_low_res)
		begin
			need_double <= 1'b0;
		end
	end

	// ****************************************
	// Result registers
	// ****************************************
	adc_level_sync #(
		.width(12)
	) u_level_sync (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(analog_input_level),
		.level_out(level_sync)
	);

	// High byte doubles as comparison reference
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_high_byte <= result_high_reset;
		end
		else if (expired && !run_compare)
		begin
			result_high_byte <= level_sync[11:4];
		end
		else if (wr_high)
		begin
			result_high_byte <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_low_data <= result_low_reset[low_data_msb:low_data_lsb];
		end
		else if (expired && run_compare)
		begin
			// Bit 7 high when reference below input
			result_low_data[low_compare_result_bit - low_data_lsb] <=
				(result_high_byte < level_sync[11:4]);
		end
		else if (expired && !run_low_res)
		begin
			// Lower four bits in 12-bit mode only
			result_low_data <= level_sync[3:0];
		end
		else if (wr_low)
		begin
			result_low_data <= pwdata[low_data_msb:low_data_lsb];
		end
	end

	// High division bit lives in the low result register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clock_divide_high <= result_low_reset[low_divide_high_bit];
		end
		else if (wr_low)
		begin
			clock_divide_high <= pwdata[low_divide_high_bit];
		end
	end

	// ****************************************
	// Operation timing
	// ****************************************
	// Comparison units; conversion units per resolution
	always_comb
	begin
		if (comparator_mode_select)
		begin
			op_units = compare_time_units;
		end
		else if (resolution_select)
		begin
			op_units = conv8_time_units;
		end
		else
		begin
			op_units = conv12_time_units;
		end
	end

	assign double_time = need_double & ~comparator_mode_select & ~resolution_select;

	// Counter loaded at launch; code scales by 2^code
	adc_cycle_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(launch),
		.abort(abort),
		.divide_code({clock_divide_high, clock_divide_low}),
		.units(op_units),
		.double_time(double_time),
		.expired(expired),
		.running()
	);

endmodule

// ### testbench/adc_sequencing_control_props.sv
// Checker of bus timing and control outputs of the converter sequencing block
`timescale 1ns/1ps
module adc_sequencing_control_props
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Analog side
	input wire logic [11:0] analog_input_level,
	input wire logic [3:0] input_channel_select,
	input wire logic sample_enable,
	input wire logic offset_compensation_enable,
	input wire logic comparator_mode_select,
	input wire logic resolution_select,
	// Interrupt
	input wire logic done_irq
);
	// ****************************************
	// Helper terms
	// ****************************************
	logic wr_ctrl;
	logic wr_mode;
	logic irq_enable_seen;
	assign wr_ctrl = psel && penable && pready && pwrite && (paddr == addr_control);
	assign wr_mode = psel && penable && pready && pwrite && (paddr == addr_mode);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_enable_seen <= 1'b0;
		else if (wr_ctrl)
			irq_enable_seen <= pwdata[ctrl_irq_enable_bit];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Properties
	// ****************************************
	property p_ready_next;
		psel && !penable |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_input_channel_select;
		wr_ctrl |=> input_channel_select == $past(pwdata[7:4])
			&& comparator_mode_select == $past(pwdata[3]);
	endproperty
	a_input_channel_select: assert property (p_input_channel_select) else $error("channel or compare select wrong");
	property p_mode;
		wr_mode |=> resolution_select == $past(pwdata[6])
			&& offset_compensation_enable == $past(pwdata[2]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode outputs wrong");
	property p_launch;
		wr_ctrl && pwdata[2] && !sample_enable |-> ##[1:2] sample_enable;
	endproperty
	a_launch: assert property (p_launch) else $error("start did not launch");
	property p_abort;
		wr_ctrl && !pwdata[2] && sample_enable |-> ##[1:2] !sample_enable;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not stop");
	property p_irq_done;
		$fell(sample_enable) && irq_enable_seen && !$past(wr_ctrl) && !$past(wr_ctrl, 2)
			|-> ##[0:2] done_irq;
	endproperty
	a_irq_done: assert property (p_irq_done) else $error("no irq at completion");
	property p_irq_off;
		wr_ctrl && !pwdata[0] |-> ##[1:2] !done_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq stays after disable");
endmodule

// ### testbench/adc_front_model.sv
// Analog front-end model giving a fixed level for each selected input
`timescale 1ns/1ps
module adc_front_model
(
	// Selection
	input wire logic [3:0] input_channel_select,
	// Digitised level
	output logic [11:0] analog_input_level
);
	// ****************************************
	// Level of the routed input
	// ****************************************
	// chosen input level
	assign analog_input_level = {input_channel_select, 8'ha6};
endmodule

// ### testbench/test_adc_sequencing_control.sv
// Testbench of the converter sequencing block
`timescale 1ns/1ps
bind adc_sequencing_control adc_sequencing_control_props u_adc_sequencing_control_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.analog_input_level(analog_input_level), .input_channel_select(input_channel_select),
	.sample_enable(sample_enable), .offset_compensation_enable(offset_compensation_enable),
	.comparator_mode_select(comparator_mode_select), .resolution_select(resolution_select),
	.done_irq(done_irq));
module test_adc_sequencing_control
	import adc_seq_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [31:0] paddr, pwdata, prdata, rd_q;
	logic [11:0] analog_input_level;
	logic [3:0] input_channel_select;
	logic sample_enable, offset_compensation_enable, comparator_mode_select;
	logic resolution_select, done_irq;
	int n_errors, tests_run;
	adc_sequencing_control #(.conv12_time_units(8'h03), .conv8_time_units(8'h02),
		.compare_time_units(8'h02)) u_adc_sequencing_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analog_input_level(analog_input_level), .input_channel_select(input_channel_select),
		.sample_enable(sample_enable), .offset_compensation_enable(offset_compensation_enable),
		.comparator_mode_select(comparator_mode_select), .resolution_select(resolution_select),
		.done_irq(done_irq));
	adc_front_model u_adc_front_model (.input_channel_select(input_channel_select),
		.analog_input_level(analog_input_level));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge pclk);
			k++;
		end
		if (k == 20)
		begin
			$display("BAD %0t: no pready", $time);
			n_errors++;
			close_out();
		end
		else
		begin
			rd_q = prdata;
			rd_err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd_q, {24'h0, exp});
	endtask
	// Start with control value c, poll done; n cycles to done plus 2 to 4 of polling
	task automatic run(input logic [7:0] c, input int n);
		time t0;
		int m;
		wr(addr_control, c);
		t0 = $time;
		m = 0;
		rd_q = 32'h0;
		while (rd_q[1] !== 1'b1 && m < 100)
		begin
			apb(1'b0, addr_control, 32'h0);
			m++;
		end
		if (m == 100)
		begin
			$display("BAD %0t: done flag never set", $time);
			n_errors++;
			close_out();
		end
		else
		begin
			m = int'((($time - t0) / 25));
			check({31'h0, m >= n + 2 && m <= n + 4}, 32'h1);
		end
	endtask
	// ****************************************
	// Stimulus
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial
	begin
		repeat (50000) @(posedge pclk);
		$display("BAD %0t: run limit reached", $time);
		n_errors++;
		close_out();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, n_errors, tests_run} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(addr_control, control_reset);
		rd(addr_mode, mode_reset);
		rd(addr_result_low, result_low_reset);
		rd(addr_result_high, result_high_reset);
		rd(32'h0000_0100, 8'h00);
		check({31'h0, rd_err}, 32'h1);
		wr(32'h0000_0100, 8'hff);
		rd(addr_control, 8'h00);
		$display("reset and map test finished");
		// Bench units: 12-bit 3, 8-bit 2, compare 2; cycles = units * 2^code + 2
		wr(addr_mode, 8'h01);
		run(8'h15, 2 * (3 * 2 + 2));
		rd(addr_control, 8'h13);
		check({31'h0, done_irq}, 32'h1);
		rd(addr_result_high, 8'h1a);
		rd(addr_result_low, 8'h60);
		wr(addr_control, 8'h13);
		rd(addr_control, 8'h13);
		wr(addr_control, 8'h11);
		rd(addr_control, 8'h11);
		check({31'h0, done_irq}, 32'h0);
		run(8'h25, 3 * 2 + 2);
		rd(addr_result_high, 8'h2a);
		wr(addr_control, 8'h20);
		$display("12-bit test finished");
		wr(addr_mode, 8'h40);
		wr(addr_result_low, 8'h50);
		run(8'h14, 2 + 2);
		rd(addr_result_high, 8'h1a);
		rd(addr_result_low, 8'h50);
		wr(addr_mode, 8'h00);
		wr(addr_control, 8'h10);
		run(8'h14, 2 * (3 + 2));
		rd(addr_result_low, 8'h60);
		wr(addr_control, 8'h10);
		run(8'h14, 3 + 2);
		$display("8-bit and switch test finished");
		wr(addr_mode, 8'h05);
		wr(addr_result_low, 8'h01);
		wr(addr_control, 8'h18);
		wr(addr_result_high, 8'h19);
		run(8'h1c, 2 * 32 + 2);
		rd(addr_result_low, 8'h81);
		wr(addr_control, 8'h18);
		wr(addr_result_high, 8'h1b);
		run(8'h1c, 2 * 32 + 2);
		rd(addr_result_low, 8'h01);
		$display("comparator test finished");
		wr(addr_mode, 8'h00);
		wr(addr_result_low, 8'h00);
		wr(addr_control, 8'h10);
		wr(addr_control, 8'h14);
		wr(addr_control, 8'h10);
		repeat (20) @(posedge pclk);
		rd(addr_control, 8'h10);
		rd(addr_result_high, 8'h1b);
		wr(addr_control, 8'h14);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		check({31'h0, sample_enable}, 32'h0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(addr_control, 8'h00);
		$display("abort and reset test finished");
		close_out();
	end
endmodule
